// file: src/ulms_pkg.sv
// Package: register map, field layout, reset values, timing and types of the status block
package ulms_pkg;
  // Register indices; the byte address is four times the index
  localparam logic [2:0] ULMS_IDX_DATA  = 3'h0;
  localparam logic [2:0] ULMS_IDX_IEN   = 3'h1;
  localparam logic [2:0] ULMS_IDX_CFG   = 3'h3;
  localparam logic [2:0] ULMS_IDX_HCTL  = 3'h4;
  localparam logic [2:0] ULMS_IDX_LSTAT = 3'h5;
  localparam logic [2:0] ULMS_IDX_HSTAT = 3'h6;
  localparam logic [2:0] ULMS_IDX_SCR   = 3'h7;
  // handshake_control fields
  localparam int ULMS_HC_TERM  = 0;
  localparam int ULMS_HC_REQ   = 1;
  localparam int ULMS_HC_AUXA  = 2;
  localparam int ULMS_HC_AUXB  = 3;
  localparam int ULMS_HC_LOOP  = 4;
  localparam int ULMS_HC_W     = 5;
  // Interrupt enable fields
  localparam int ULMS_IE_RXD   = 0;
  localparam int ULMS_IE_THR   = 1;
  localparam int ULMS_IE_LINE  = 2;
  localparam int ULMS_IE_HSK   = 3;
  // Configuration fields
  localparam int ULMS_CF_PAREN = 0;
  localparam int ULMS_CF_EVEN  = 1;
  localparam int ULMS_CF_FIFO  = 2;
  // Reset values
  localparam logic [7:0] ULMS_HCTL_RST = 8'h00;
  localparam logic [7:0] ULMS_IEN_RST  = 8'h00;
  localparam logic [7:0] ULMS_CFG_RST  = 8'h00;
  localparam logic [7:0] ULMS_SCR_RST  = 8'h00;
  // Timing: bit time in clock cycles of the 200 MHz clock
  localparam int ULMS_CLK_MHZ      = 200;
  localparam int ULMS_BIT_CYCLES   = 16;
  localparam int ULMS_FIFO_DEPTH   = 16;

  typedef struct packed {
    logic       brk;
    logic       fe;
    logic       pe;
    logic [7:0] data;
  } ulms_rxchar_s;

  typedef enum logic [2:0] {
    RX_IDLE  = 3'b000,
    RX_START = 3'b001,
    RX_DATA  = 3'b010,
    RX_PAR   = 3'b011,
    RX_STOP  = 3'b100,
    RX_BRKW  = 3'b101
  } ulms_rxst_e;
endpackage

// file: src/ulms_rx.sv
// Receiver: start detect, data, parity, stop, framing resync and break capture
`timescale 1ns/1ps
module ulms_rx
  import ulms_pkg::*;
#(
  parameter int BIT_CYCLES = ULMS_BIT_CYCLES
) (
  input  wire logic   clock,
  input  wire logic   nrst,
  input  wire logic   rxBit,
  input  wire logic   parEn,
  input  wire logic   parEven,
  output ulms_rxchar_s rxChar,
  output logic        rxValid
);
  localparam logic [15:0] FULL = 16'(BIT_CYCLES - 1);
  localparam logic [15:0] HALF = 16'(BIT_CYCLES / 2 - 1);

  ulms_rxst_e  st_r;
  logic [15:0] cnt_r;
  logic [2:0]  bitIdx_r;
  logic [7:0]  shift_r;
  logic        parBit_r;
  logic        allZero_r;
  logic        brkNow;

  assign brkNow = !rxBit && allZero_r;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_r      <= RX_IDLE;
      cnt_r     <= 16'h0000;
      bitIdx_r  <= 3'h0;
      shift_r   <= 8'h00;
      parBit_r  <= 1'b0;
      allZero_r <= 1'b0;
      rxValid   <= 1'b0;
      rxChar    <= '0;
    end else begin
      rxValid <= 1'b0;
      if (st_r != RX_IDLE && st_r != RX_BRKW && cnt_r != 16'h0000) begin
        cnt_r <= cnt_r - 16'h0001;
      end else begin
        case (st_r)
          RX_IDLE: begin
            if (!rxBit) begin
              cnt_r <= HALF;
              st_r  <= RX_START;
            end
          end
          RX_START: begin
            if (rxBit) begin
              st_r <= RX_IDLE;
            end else begin
              cnt_r     <= FULL;
              bitIdx_r  <= 3'h0;
              allZero_r <= 1'b1;
              st_r      <= RX_DATA;
            end
          end
          RX_DATA: begin
            shift_r   <= {rxBit, shift_r[7:1]};
            allZero_r <= allZero_r & !rxBit;
            cnt_r     <= FULL;
            bitIdx_r  <= bitIdx_r + 3'h1;
            if (bitIdx_r == 3'h7) begin
              st_r <= parEn ? RX_PAR : RX_STOP;
            end
          end
          RX_PAR: begin
            parBit_r  <= rxBit;
            allZero_r <= allZero_r & !rxBit;
            cnt_r     <= FULL;
            st_r      <= RX_STOP;
          end
          RX_STOP: begin
            rxValid <= 1'b1;
            rxChar.pe   <= parEn && ((^{shift_r, parBit_r}) == parEven);
            rxChar.fe   <= !rxBit;
            rxChar.brk  <= brkNow;
            rxChar.data <= brkNow ? 8'h00 : shift_r;
            cnt_r       <= HALF;
            if (brkNow) begin
              st_r <= RX_BRKW;
            end else if (!rxBit) begin
              st_r <= RX_START;
            end else begin
              st_r <= RX_IDLE;
            end
          end
          RX_BRKW: begin
            if (!rxBit) begin
              cnt_r <= HALF;
            end else if (cnt_r != 16'h0000) begin
              cnt_r <= cnt_r - 16'h0001;
            end else begin
              st_r <= RX_IDLE;
            end
          end
          default: st_r <= RX_IDLE;
        endcase
      end
    end
  end
endmodule

// file: src/ulms_tx.sv
// Transmitter: holding register feeding a shift register
`timescale 1ns/1ps
module ulms_tx
  import ulms_pkg::*;
#(
  parameter int BIT_CYCLES = ULMS_BIT_CYCLES
) (
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       wrStb,
  input  wire logic [7:0] wrData,
  input  wire logic       parEn,
  input  wire logic       parEven,
  output logic            txBit,
  output logic            holdEmpty,
  output logic            shiftEmpty
);
  localparam logic [15:0] FULL = 16'(BIT_CYCLES - 1);

  logic [7:0]  hold_r;
  logic [10:0] frame_r;
  logic [3:0]  left_r;
  logic [15:0] cnt_r;
  logic        load;

  assign load = !holdEmpty && shiftEmpty;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      hold_r    <= 8'h00;
      holdEmpty <= 1'b1;
    end else if (wrStb) begin
      hold_r    <= wrData;
      holdEmpty <= 1'b0;
    end else if (load) begin
      holdEmpty <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      frame_r    <= '1;
      left_r     <= 4'h0;
      cnt_r      <= 16'h0000;
      shiftEmpty <= 1'b1;
      txBit      <= 1'b1;
    end else if (load) begin
      frame_r    <= {1'b1, parEven ? ^hold_r : ~^hold_r, hold_r, 1'b0};
      left_r     <= parEn ? 4'hb : 4'ha;
      cnt_r      <= 16'h0000;
      shiftEmpty <= 1'b0;
    end else if (!shiftEmpty) begin
      if (cnt_r != 16'h0000) begin
        cnt_r <= cnt_r - 16'h0001;
      end else if (left_r == 4'h0) begin
        shiftEmpty <= 1'b1;
        txBit      <= 1'b1;
      end else begin
        // Without parity the last slot is the stop bit, not the parity bit
        txBit   <= parEn || left_r != 4'h1 ? frame_r[0] : 1'b1;
        frame_r <= {1'b1, frame_r[10:1]};
        left_r  <= left_r - 4'h1;
        cnt_r   <= FULL;
      end
    end
  end
endmodule

// file: src/ulms_uart_status.sv
// Serial port status block: bus slave, line and handshake status, loopback
// What this block does
// - Aux output B enables interrupt pin drive
// - Loopback: line mark, transmitter feeds receiver
// - Loopback: handshake inputs from control bits
// - Loopback handshake events from control bits
// - Control upper three bits read zero
// - Data ready until receive data drained
// - Overrun when full; character dropped
// - Parity error reported with head character
// - Framing error reported with head character
// - Resync treating bad stop as start
// - Break when frame stays at space
// - One zero character per break
// - Line errors raise enabled interrupt
// - Holding empty set on move, cleared on write
// - All empty when holding and shifter empty
// - Top status bit flags FIFO errors
// - Handshake deltas set on change, read clears
// - Ring trailing edge only on rise
// - Any delta raises handshake interrupt
// - Upper status bits show inverted inputs
// - Scratchpad byte stores host data
// - Control bits drive ready and request pins outside loopback; loopback holds them inactive
`timescale 1ns/1ps
module ulms_uart_status
  import ulms_pkg::*;
#(
  parameter int BIT_CYCLES = ULMS_BIT_CYCLES,
  parameter int DEPTH      = ULMS_FIFO_DEPTH
) (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        rxd_in,
  input  wire logic        clear_send_in_n,
  input  wire logic        set_ready_in_n,
  input  wire logic        ring_in_n,
  input  wire logic        carrier_in_n,
  output logic             txd_out,
  output logic             term_ready_out_n,
  output logic             req_send_out_n,
  output logic             irqOut,
  output logic             irqOeN
);
  localparam int PW = $clog2(DEPTH);

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: reads take one wait state so a write just before is seen
  logic       rdPend_r;
  logic       wrPend_r;
  logic [2:0] idx_r;
  logic       mapped_r;
  logic       accept;
  logic [7:0] rdValue;
  logic       wrEn;
  logic       rdEn;

  assign accept = hsel && htrans[1] && hready;
  assign wrEn   = wrPend_r && mapped_r;
  assign rdEn   = rdPend_r && mapped_r;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rdPend_r  <= 1'b0;
      wrPend_r  <= 1'b0;
      idx_r     <= 3'h0;
      mapped_r  <= 1'b0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end else begin
      wrPend_r <= 1'b0;
      rdPend_r <= 1'b0;
      if (rdPend_r) begin
        hrdata    <= {24'h000000, mapped_r ? rdValue : 8'h00};
        hreadyout <= 1'b1;
      end else if (accept) begin
        idx_r     <= haddr[4:2];
        mapped_r  <= haddr[31:5] == 27'h0000000 && haddr[1:0] == 2'h0;
        wrPend_r  <= hwrite;
        rdPend_r  <= !hwrite;
        hreadyout <= hwrite;
      end
    end
  end

  logic dataRd;
  logic lstRd;
  logic hstRd;
  assign dataRd = rdEn && idx_r == ULMS_IDX_DATA;
  assign lstRd  = rdEn && idx_r == ULMS_IDX_LSTAT;
  assign hstRd  = rdEn && idx_r == ULMS_IDX_HSTAT;

  ////////////////////////////////////////////////////////////////////////////
  // Software registers
  logic [ULMS_HC_W-1:0] hctl_r;
  logic [3:0]           ien_r;
  logic [2:0]           cfg_r;
  logic [7:0]           scr_r;
  logic                 loop;
  logic                 fifoMode;

  assign loop     = hctl_r[ULMS_HC_LOOP];
  assign fifoMode = cfg_r[ULMS_CF_FIFO];

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      hctl_r <= ULMS_HCTL_RST[ULMS_HC_W-1:0];
      ien_r  <= ULMS_IEN_RST[3:0];
      cfg_r  <= ULMS_CFG_RST[2:0];
      scr_r  <= ULMS_SCR_RST;
    end else if (wrEn) begin
      if (idx_r == ULMS_IDX_HCTL) begin
        hctl_r <= hwdata[ULMS_HC_W-1:0];
      end else if (idx_r == ULMS_IDX_IEN) begin
        ien_r <= hwdata[3:0];
      end else if (idx_r == ULMS_IDX_CFG) begin
        cfg_r <= hwdata[2:0];
      end else if (idx_r == ULMS_IDX_SCR) begin
        scr_r <= hwdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: {carrier, ring, setReady, clearSend, rxd}
  logic [4:0] pinMeta_r;
  logic [4:0] pinSync_r;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pinMeta_r <= 5'h1f;
      pinSync_r <= 5'h1f;
    end else begin
      pinMeta_r <= {carrier_in_n, ring_in_n, set_ready_in_n, clear_send_in_n, rxd_in};
      pinSync_r <= pinMeta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter and receiver
  logic         txBit;
  logic         holdEmpty;
  logic         shiftEmpty;
  logic         rxIn;
  logic         rxValid;
  ulms_rxchar_s rxChar;

  ulms_tx #(
    .BIT_CYCLES (BIT_CYCLES)
  ) u_tx (
    .clock      (clock),
    .nrst       (nrst),
    .wrStb      (wrEn && idx_r == ULMS_IDX_DATA),
    .wrData     (hwdata[7:0]),
    .parEn      (cfg_r[ULMS_CF_PAREN]),
    .parEven    (cfg_r[ULMS_CF_EVEN]),
    .txBit      (txBit),
    .holdEmpty  (holdEmpty),
    .shiftEmpty (shiftEmpty)
  );

  assign rxIn = loop ? txBit : pinSync_r[0];

  ulms_rx #(
    .BIT_CYCLES (BIT_CYCLES)
  ) u_rx (
    .clock   (clock),
    .nrst    (nrst),
    .rxBit   (rxIn),
    .parEn   (cfg_r[ULMS_CF_PAREN]),
    .parEven (cfg_r[ULMS_CF_EVEN]),
    .rxChar  (rxChar),
    .rxValid (rxValid)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Receive buffer; outside FIFO mode it holds a single character
  ulms_rxchar_s  mem_r [DEPTH];
  logic [PW-1:0] wrPtr_r;
  logic [PW-1:0] rdPtr_r;
  logic [PW:0]   count_r;
  logic [PW:0]   errCnt_r;
  logic          full;
  logic          push;
  logic          pop;
  logic          fifoMode_r;
  logic          newErr;
  logic          headErr;
  ulms_rxchar_s  head;

  assign full    = count_r >= (fifoMode ? (PW+1)'(DEPTH) : (PW+1)'(1));
  assign push    = rxValid && !full;
  assign pop     = dataRd && count_r != '0;
  assign head    = mem_r[rdPtr_r];
  assign newErr  = rxChar.pe || rxChar.fe || rxChar.brk;
  assign headErr = head.pe || head.fe || head.brk;

  always_ff @(posedge clock) begin
    if (push) begin
      mem_r[wrPtr_r] <= rxChar;
    end
  end

  // Switching mode empties the buffer so both modes start clean
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wrPtr_r    <= '0;
      rdPtr_r    <= '0;
      count_r    <= '0;
      errCnt_r   <= '0;
      fifoMode_r <= 1'b0;
    end else begin
      fifoMode_r <= fifoMode;
      if (fifoMode_r != fifoMode) begin
        wrPtr_r  <= '0;
        rdPtr_r  <= '0;
        count_r  <= '0;
        errCnt_r <= '0;
      end else begin
        if (push) begin
          wrPtr_r <= wrPtr_r + PW'(1);
        end
        if (pop) begin
          rdPtr_r <= rdPtr_r + PW'(1);
        end
        count_r  <= count_r + (PW+1)'(push) - (PW+1)'(pop);
        errCnt_r <= errCnt_r + (PW+1)'(push && newErr) - (PW+1)'(pop && headErr);
      end
    end
  end

  // Error flags of the character that becomes the head of the buffer
  logic       headLoad;
  logic [2:0] nextHeadFlags;
  ulms_rxchar_s afterHead;

  assign afterHead = mem_r[rdPtr_r + PW'(1)];

  always_comb begin
    headLoad      = 1'b0;
    nextHeadFlags = 3'h0;
    if (push && (count_r == '0 || (pop && count_r == (PW+1)'(1)))) begin
      headLoad      = 1'b1;
      nextHeadFlags = {rxChar.brk, rxChar.fe, rxChar.pe};
    end else if (pop && count_r > (PW+1)'(1)) begin
      headLoad      = 1'b1;
      nextHeadFlags = {afterHead.brk, afterHead.fe, afterHead.pe};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line status flags: a new event wins over the clearing read
  logic overrun_r;
  logic parErr_r;
  logic frmErr_r;
  logic brk_r;
  logic fifoErr_r;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      overrun_r <= 1'b0;
    end else if (rxValid && full) begin
      overrun_r <= 1'b1;
    end else if (lstRd) begin
      overrun_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      parErr_r <= 1'b0;
      frmErr_r <= 1'b0;
      brk_r    <= 1'b0;
    end else begin
      parErr_r <= (headLoad && nextHeadFlags[0]) || (parErr_r && !lstRd);
      frmErr_r <= (headLoad && nextHeadFlags[1]) || (frmErr_r && !lstRd);
      brk_r    <= (headLoad && nextHeadFlags[2]) || (brk_r && !lstRd);
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      fifoErr_r <= 1'b0;
    end else if (push && newErr) begin
      fifoErr_r <= 1'b1;
    end else if (lstRd && errCnt_r == '0) begin
      fifoErr_r <= 1'b0;
    end
  end

  logic [7:0] lineStatus;
  assign lineStatus = {fifoMode && fifoErr_r, holdEmpty && shiftEmpty, holdEmpty,
                       brk_r, frmErr_r, parErr_r, overrun_r, count_r != '0};

  ////////////////////////////////////////////////////////////////////////////
  // Handshake inputs, active high: {carrier, ring, setReady, clearSend}
  logic [3:0] hskAct;
  logic [3:0] hskPrev_r;
  logic [3:0] delta_r;
  logic [3:0] deltaSet;

  assign hskAct = loop ? {hctl_r[ULMS_HC_AUXB], hctl_r[ULMS_HC_AUXA],
                          hctl_r[ULMS_HC_TERM], hctl_r[ULMS_HC_REQ]}
                       : ~pinSync_r[4:1];

  assign deltaSet = {hskAct[3] ^ hskPrev_r[3], hskPrev_r[2] && !hskAct[2],
                     hskAct[1] ^ hskPrev_r[1], hskAct[0] ^ hskPrev_r[0]};

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      hskPrev_r <= 4'h0;
      delta_r   <= 4'h0;
    end else begin
      hskPrev_r <= hskAct;
      delta_r   <= deltaSet | (hstRd ? 4'h0 : delta_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read multiplexer
  always_comb begin
    rdValue = 8'h00;
    if (idx_r == ULMS_IDX_DATA) begin
      rdValue = count_r != '0 ? head.data : 8'h00;
    end else if (idx_r == ULMS_IDX_IEN) begin
      rdValue = {4'h0, ien_r};
    end else if (idx_r == ULMS_IDX_CFG) begin
      rdValue = {5'h00, cfg_r};
    end else if (idx_r == ULMS_IDX_HCTL) begin
      rdValue = {3'h0, hctl_r};
    end else if (idx_r == ULMS_IDX_LSTAT) begin
      rdValue = lineStatus;
    end else if (idx_r == ULMS_IDX_HSTAT) begin
      rdValue = {hskAct, delta_r};
    end else if (idx_r == ULMS_IDX_SCR) begin
      rdValue = scr_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial interrupt request
  logic irqLevel;

  assign irqLevel = (ien_r[ULMS_IE_RXD] && count_r != '0)
                 || (ien_r[ULMS_IE_THR] && holdEmpty)
                 || (ien_r[ULMS_IE_LINE] && (overrun_r || parErr_r || frmErr_r || brk_r))
                 || (ien_r[ULMS_IE_HSK] && delta_r != 4'h0);

  ////////////////////////////////////////////////////////////////////////////
  // Pin outputs
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      txd_out          <= 1'b1;
      term_ready_out_n <= 1'b1;
      req_send_out_n   <= 1'b1;
      irqOut           <= 1'b0;
      irqOeN           <= 1'b1;
    end else begin
      txd_out          <= loop ? 1'b1 : txBit;
      term_ready_out_n <= loop ? 1'b1 : !hctl_r[ULMS_HC_TERM];
      req_send_out_n   <= loop ? 1'b1 : !hctl_r[ULMS_HC_REQ];
      irqOut           <= irqLevel;
      // drive only with aux B set
      irqOeN           <= !hctl_r[ULMS_HC_AUXB];
    end
  end
endmodule

// file: testbench/ulms_status_props.sv
// Checker of bus timing, control pins and register readback
`timescale 1ns/1ps
module ulms_status_chk
  import ulms_pkg::*;
#(
  parameter int BIT_CYCLES = ULMS_BIT_CYCLES,
  parameter int DEPTH      = ULMS_FIFO_DEPTH
) (
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        txd_out,
  input wire logic        term_ready_out_n,
  input wire logic        req_send_out_n,
  input wire logic        irqOeN
);
  logic       rdP, wrP, bad;
  logic [2:0] idx;
  logic [7:0] ctl, scratchpad;
  wire        take = hsel & htrans[1] & hready;
  wire        done = rdP & hready & !bad;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rdP <= 1'b0;
      wrP <= 1'b0;
    end else if (take | hready) begin
      rdP <= take & !hwrite;
      wrP <= take & hwrite;
    end
  end
  always_ff @(posedge clock) begin
    if (take) begin
      idx <= haddr[4:2];
      bad <= (|haddr[31:5]) | (|haddr[1:0]);
    end
  end
  // Shadow of what software wrote, to judge readback and pins
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctl <= 8'h00;
      scratchpad <= 8'h00;
    end else if (wrP && hready && !bad) begin
      if (idx == ULMS_IDX_HCTL) ctl <= hwdata[7:0];
      if (idx == ULMS_IDX_SCR) scratchpad <= hwdata[7:0];
    end
  end
  ////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  chk_resp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
  chk_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait wrong");
  chk_write_fast: assert property (take && hwrite |=> hreadyout) else $error("write stalled");
  chk_ctl_upper: assert property (done && idx == ULMS_IDX_HCTL |->
    hrdata == {27'h0, ctl[4:0]}) else $error("control readback wrong");
  chk_scr_hold: assert property (done && idx == ULMS_IDX_SCR |->
    hrdata == {24'h0, scratchpad}) else $error("scratchpad readback wrong");
  chk_unmapped_zero: assert property (rdP && hready && bad |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  chk_irq_gate: assert property (ctl == $past(ctl, 2) |-> irqOeN == !ctl[3])
    else $error("irq enable wrong");
  chk_pin_drive: assert property (ctl == $past(ctl, 2) |->
    term_ready_out_n == (ctl[4] | !ctl[0]) && req_send_out_n == (ctl[4] | !ctl[1]))
    else $error("handshake pin wrong");
  chk_loop_mark: assert property (ctl[4] && ctl == $past(ctl, 2) |-> txd_out)
    else $error("txd not mark in loopback");
  chk_loop_status: assert property (done && idx == ULMS_IDX_HSTAT && ctl[4] &&
    ctl == $past(ctl, 4) |-> hrdata[7:4] == {ctl[3], ctl[2], ctl[0], ctl[1]})
    else $error("loopback status wrong");
endmodule
bind ulms_uart_status ulms_status_chk #(.BIT_CYCLES(BIT_CYCLES), .DEPTH(DEPTH)) chk (.*);

// file: testbench/ulms_modem_peer.sv
// Modem peer: drives the handshake pins and serial frames into the block
`timescale 1ns/1ps
module ulms_modem_peer
  import ulms_pkg::*;
#(
  parameter int BT = ULMS_BIT_CYCLES
) (
  input  wire logic clock,
  output logic      rxd_in,
  output logic      clear_send_in_n,
  output logic      set_ready_in_n,
  output logic      ring_in_n,
  output logic      carrier_in_n
);
  initial begin
    rxd_in = 1'b1;
    {carrier_in_n, ring_in_n, set_ready_in_n, clear_send_in_n} = 4'hf;
  end
  task automatic setPins(input logic [3:0] p);
    @(posedge clock);
    {carrier_in_n, ring_in_n, set_ready_in_n, clear_send_in_n} <= p;
  endtask
  // Bits leave LSB first, one bit time each
  task automatic sendFrame(input logic [14:0] b, input int n);
    @(posedge clock);
    for (int i = 0; i < n; i++) begin
      rxd_in <= b[i];
      repeat (BT) @(posedge clock);
    end
    // mark kept a full bit so the receiver may restart
    rxd_in <= 1'b1;
    repeat (BT) @(posedge clock);
  endtask
endmodule

// file: testbench/ulms_uart_status_tb.sv
// Self-checking bench of the serial port status block
`timescale 1ns/1ps
module ulms_uart_status_tb import ulms_pkg::*; ;
  localparam int BT = 8;
  logic        clock, nrst, hsel, hwrite, hreadyout, hresp, txd_out;
  logic        term_ready_out_n, req_send_out_n, irqOut, irqOeN, rxd_in;
  logic        clear_send_in_n, set_ready_in_n, ring_in_n, carrier_in_n;
  logic [31:0] haddr, hwdata, hrdata, rnd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  v, x;
  logic [3:0]  p;
  wire         hready = hreadyout;
  int          error_cnt, comparisons;
  ulms_uart_status #(.BIT_CYCLES(BT)) uut (.*);
  ulms_modem_peer #(.BT(BT)) peer (.*);
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  ////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Even parity bit, optionally spoilt
  function automatic logic [14:0] frm(input logic [7:0] d, input logic e, input logic stp);
    return {4'hf, stp, ^d ^ e, d, 1'b0};
  endfunction
  task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Sample before the edge, so the edge itself ends the phase
  task automatic busWait(output logic [7:0] d);
    for (int n = 0; n < 40; n++) begin
      @(negedge clock);
      d = hrdata[7:0];
      if (hready) begin
        @(posedge clock);
        return;
      end
    end
    error_cnt++;
    summarize();
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] wd,
                     output logic [7:0] rd);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    busWait(rd);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    busWait(rd);
  endtask
  task automatic wr(input logic [2:0] i, input logic [7:0] d);
    bus(1'b1, {27'h0, i, 2'b00}, d, x);
  endtask
  task automatic rd(input string nm, input logic [2:0] i, input logic [7:0] e);
    bus(1'b0, {27'h0, i, 2'b00}, 8'h00, x);
    check(nm, e, x);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic rxCase(input logic [7:0] d, input logic e, input logic s, input logic [7:0] ls);
    peer.sendFrame(frm(d, e, s), 11);
    rd("line_status", ULMS_IDX_LSTAT, ls);
    rd("rx_data", ULMS_IDX_DATA, d);
  endtask
  ////////////////////
  initial begin
    {nrst, hsel, hwrite, haddr, hwdata, htrans, error_cnt, comparisons} = '0;
    hsize = 3'h2;
    rnd = 32'h96c4;
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      rnd = lfsr(rnd);
      v = rnd[15:8] & 8'hef;
      wr(ULMS_IDX_SCR, rnd[7:0]);
      rd("scratchpad", ULMS_IDX_SCR, rnd[7:0]);
      wr(ULMS_IDX_HCTL, v);
      rd("handshake_control", ULMS_IDX_HCTL, {3'h0, v[4:0]});
      idle(4);
      check("irq_oe_n", {7'h0, ~v[3]}, {7'h0, irqOeN});
      check("term_ready", {7'h0, ~v[0]}, {7'h0, term_ready_out_n});
    end
    bus(1'b1, 32'h1d, 8'h5a, x);
    bus(1'b0, 32'h20, 8'h00, x);
    check("unmapped", 8'h00, x);
    rd("scratchpad", ULMS_IDX_SCR, rnd[7:0]);
    $display("test registers done");
    wr(ULMS_IDX_IEN, 8'h08);
    wr(ULMS_IDX_HCTL, 8'h08);
    bus(1'b0, {27'h0, ULMS_IDX_HSTAT, 2'b00}, 8'h00, x);
    for (int i = 0; i < 4; i++) begin
      p = 4'hf;
      p[i] = 1'b0;
      peer.setPins(p);
      idle(6);
      check("irq", {7'h0, i != 2}, {7'h0, irqOut});
      rd("handshake_status", ULMS_IDX_HSTAT, {~p, i == 2 ? 4'h0 : ~p});
      peer.setPins(4'hf);
      idle(6);
      check("irq", 8'h01, {7'h0, irqOut});
      rd("handshake_status", ULMS_IDX_HSTAT, 8'h01 << i);
      idle(3);
      check("irq", 8'h00, {7'h0, irqOut});
    end
    $display("test handshake done");
    wr(ULMS_IDX_CFG, 8'h03);
    rnd = lfsr(rnd);
    rxCase(rnd[7:0], 1'b0, 1'b1, 8'h61);
    rxCase(rnd[15:8], 1'b1, 1'b1, 8'h65);
    rxCase(rnd[23:16] | 8'h80, 1'b0, 1'b0, 8'h69);
    peer.sendFrame(15'h0, 14);
    rxCase(8'h00, 1'b0, 1'b1, 8'h7b);
    wr(ULMS_IDX_IEN, 8'h0c);
    peer.sendFrame(frm(rnd[7:0], 1'b0, 1'b1), 11);
    peer.sendFrame(frm(rnd[15:8], 1'b0, 1'b1), 11);
    check("irq", 8'h01, {7'h0, irqOut});
    rd("line_status", ULMS_IDX_LSTAT, 8'h63);
    rd("line_status", ULMS_IDX_LSTAT, 8'h61);
    rd("rx_data", ULMS_IDX_DATA, rnd[7:0]);
    rd("line_status", ULMS_IDX_LSTAT, 8'h60);
    wr(ULMS_IDX_CFG, 8'h07);
    peer.sendFrame(frm(rnd[7:0], 1'b1, 1'b1), 11);
    peer.sendFrame(frm(rnd[15:8], 1'b0, 1'b1), 11);
    rd("line_status", ULMS_IDX_LSTAT, 8'he5);
    rd("rx_data", ULMS_IDX_DATA, rnd[7:0]);
    rd("rx_data", ULMS_IDX_DATA, rnd[15:8]);
    rd("line_status", ULMS_IDX_LSTAT, 8'he0);
    $display("test receive done");
    wr(ULMS_IDX_HCTL, 8'h1f);
    peer.setPins(4'h0);
    bus(1'b0, {27'h0, ULMS_IDX_HSTAT, 2'b00}, 8'h00, x);
    wr(ULMS_IDX_HCTL, 8'h1e);
    idle(4);
    check("irq", 8'h01, {7'h0, irqOut});
    rd("handshake_status", ULMS_IDX_HSTAT, 8'hd2);
    wr(ULMS_IDX_DATA, rnd[31:24]);
    idle(14 * BT);
    rd("line_status", ULMS_IDX_LSTAT, 8'h61);
    rd("rx_data", ULMS_IDX_DATA, rnd[31:24]);
    $display("test loopback done");
    summarize();
  end
endmodule
